// >>> qpd_pkg.sv
// constants shared by the quad potentiometer command decoder
package qpd_pkg;

	localparam int WORD_W = 16;
	localparam int CODE_W = 6;
	localparam int TAPS = 64;
	localparam int WIPERS = 4;
	localparam int NV_DEPTH = 16;
	localparam int NV_W = 8;
	localparam int CNT_W = 4;
	localparam int SYNC_STAGES = 2;

	// word layout
	localparam int CMD_MSB = 15;
	localparam int CMD_LSB = 12;
	localparam int ADDR_MSB = 11;
	localparam int ADDR_LSB = 8;
	localparam int DATA_MSB = 7;
	localparam int DATA_LSB = 0;

	// bit counter value on the last rising edge of a frame
	localparam logic [3:0] LAST_BIT = 4'hf;
	localparam logic [3:0] FIRST_BIT = 4'h0;

	// wiper codes
	localparam logic [5:0] CODE_ZERO = 6'h00;
	localparam logic [5:0] CODE_ONE = 6'h01;
	localparam logic [5:0] CODE_MID = 6'h20;
	localparam logic [5:0] CODE_FULL = 6'h3f;

	// store contents after rst; wiper slots are the first four addresses
	localparam logic [7:0] NV_RESET_WIPER = 8'h20;
	localparam logic [7:0] NV_RESET_USER = 8'h00;
	localparam logic [3:0] NV_WIPER_LAST = 4'h3;

	// instruction nibbles
	typedef enum logic [3:0] {
		CMD_IDLE = 4'h0,
		CMD_RESTORE_ONE = 4'h1,
		CMD_STORE_WIPER = 4'h2,
		CMD_STORE_BYTE = 4'h3,
		CMD_SHR_ONE = 4'h4,
		CMD_SHR_ALL = 4'h5,
		CMD_DEC_ONE = 4'h6,
		CMD_DEC_ALL = 4'h7,
		CMD_RESTORE_ALL = 4'h8,
		CMD_READ_STORE = 4'h9,
		CMD_READ_WIPER = 4'ha,
		CMD_WRITE_WIPER = 4'hb,
		CMD_SHL_ONE = 4'hc,
		CMD_SHL_ALL = 4'hd,
		CMD_INC_ONE = 4'he,
		CMD_INC_ALL = 4'hf
	} qpd_cmd_t;

endpackage

// >>> qpd_tap_if.sv
// wiper codes towards the tap decoder and the one-hot taps back
`timescale 1ns/10ps
interface qpd_tap_if #(
	parameter int WIPERS = 4,
	parameter int CODE_W = 6,
	parameter int TAPS = 64
);
	logic [WIPERS-1:0][CODE_W-1:0] code;
	logic [WIPERS-1:0][TAPS-1:0] tap;

	modport ctrl (output code, input tap);
	modport dec (input code, output tap);
endinterface

// >>> qpd_tap_decoder.sv
// one-hot tap selection for every wiper
`timescale 1ns/10ps
module qpd_tap_decoder #(
	parameter int WIPERS = 4,
	parameter int CODE_W = 6,
	parameter int TAPS = 64
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// codes in, taps out
	qpd_tap_if.dec taps
);

	genvar i;
	generate
		for (i = 0; i < WIPERS; i++) begin : g_wiper
			// code zero is the B end; each step moves one tap toward A
			always_ff @(posedge clk) begin
				if (rst) begin
					taps.tap[i] <= TAPS'(1);
				end else begin
					taps.tap[i] <= TAPS'(1) << taps.code[i];
				end
			end
		end
	endgenerate

endmodule

// >>> qpd_command_decoder.sv
// serial command decoder and wiper logic of a quad 64-position potentiometer
`timescale 1ns/10ps

// Behaviour
// - each wiper holds a 6-bit code selecting exactly one of 64 taps.
// - code zero selects the tap at the B end, zero scale.
// - each code step moves one tap toward A, up to code 63.
// - nibble B with address zero loads the data byte into the first wiper.
// - 0xE0XX increments the wiper; output shifts the previous frame's word.
// - 0x20XX copies the first wiper into its saved slot.
// - while write-protect is low, nonvolatile stores are blocked.
// - 0x10XX reloads the first wiper from its saved slot.
// - wipers reload from the store at power-on and on restore strobe.
// - 0xC0XX left-shifts the first wiper, doubling codes 1 to 31.
// - nibble 3 writes the data byte into the addressed store location.
// - twelve user store locations of eight bits each are provided.
// - nibble 9 prepares a read of the addressed store location.
// - next frame's output word carries the read contents in its low byte.
// - the idle instruction changes nothing and returns to low power.
// - 0xA0XX prepares a wiper readback; next output low byte holds the code.
// - left shift of midscale 0x20 yields full scale, not overflow.
// - a received instruction executes only once chip select returns high.
// - left shift of zero gives one; at or above midscale gives full scale.
// - a byte stored into a wiper slot counts only its low six bits.
module qpd_command_decoder #(
	parameter int WIPERS = qpd_pkg::WIPERS,
	parameter int CODE_W = qpd_pkg::CODE_W,
	parameter int TAPS = qpd_pkg::TAPS,
	parameter int NV_DEPTH = qpd_pkg::NV_DEPTH
) (
	// system clock and reset
	input wire logic clk,
	input wire logic rst,
	// serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	// side pins
	input wire logic wp_n,
	input wire logic restore_strobe_pin_n,
	// wiper state
	output logic [WIPERS-1:0][CODE_W-1:0] wiper_code,
	output logic [WIPERS-1:0][TAPS-1:0] tap_sel,
	output logic read_power_state
);

	localparam int W = qpd_pkg::WORD_W;
	localparam int NW = qpd_pkg::NV_W;
	localparam int SS = qpd_pkg::SYNC_STAGES;

	////////////////////////////////////////////////////////////////////////
	// functions

	function automatic logic [CODE_W-1:0] shl_code(input logic [CODE_W-1:0] c);
		logic [CODE_W-1:0] r;
		r = CODE_W'(c << 1);
		if (c == qpd_pkg::CODE_ZERO) begin
			r = qpd_pkg::CODE_ONE;
		end else if (c >= qpd_pkg::CODE_MID) begin
			r = qpd_pkg::CODE_FULL;
		end
		return r;
	endfunction

	function automatic logic [CODE_W-1:0] inc_code(input logic [CODE_W-1:0] c);
		logic [CODE_W-1:0] r;
		r = (c == qpd_pkg::CODE_FULL) ? c : CODE_W'(c + CODE_W'(1));
		return r;
	endfunction

	function automatic logic [CODE_W-1:0] dec_code(input logic [CODE_W-1:0] c);
		logic [CODE_W-1:0] r;
		r = (c == qpd_pkg::CODE_ZERO) ? c : CODE_W'(c - CODE_W'(1));
		return r;
	endfunction

	function automatic logic is_wiper_addr(input logic [3:0] a);
		return a <= qpd_pkg::NV_WIPER_LAST;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// link domain: receive and transmit shifters

	logic [3:0] bit_cnt_ff;
	logic [W-1:0] rx_sh_ff;
	logic [W-1:0] rx_word_ff;
	logic rx_tgl_ff;
	logic sdo_ff;
	logic [W-1:0] out_word_ff;

	// counts rising edges; chip select high clears it at once
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt_ff <= qpd_pkg::FIRST_BIT;
		end else begin
			bit_cnt_ff <= bit_cnt_ff + 4'h1;
		end
	end

	always_ff @(posedge sclk) begin
		rx_sh_ff <= {rx_sh_ff[W-2:0], sdi};
	end

	// whole word held and announced by a toggle on the sixteenth edge
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			rx_word_ff <= '0;
			rx_tgl_ff <= 1'b0;
		end else if (bit_cnt_ff == qpd_pkg::LAST_BIT) begin
			rx_word_ff <= {rx_sh_ff[W-2:0], sdi};
			rx_tgl_ff <= ~rx_tgl_ff;
		end
	end

	// out_word_ff only changes between frames, so it is steady here
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			sdo_ff <= 1'b0;
		end else begin
			sdo_ff <= out_word_ff[~bit_cnt_ff];
		end
	end

	// msb has to stand before the first rising edge
	assign sdo = (bit_cnt_ff == qpd_pkg::FIRST_BIT) ? out_word_ff[W-1] : sdo_ff;
	assign sdo_oe = ~cs_n;

	////////////////////////////////////////////////////////////////////////
	// crossings into the system clock

	logic [SS-1:0] cs_sync_ff;
	logic [SS-1:0] tgl_sync_ff;
	logic [SS-1:0] wp_sync_ff;
	logic [SS-1:0] strobe_sync_ff;
	logic strobe_prev_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			cs_sync_ff <= '1;
			tgl_sync_ff <= '0;
			wp_sync_ff <= '0;
			strobe_sync_ff <= '1;
		end else begin
			cs_sync_ff <= {cs_sync_ff[SS-2:0], cs_n};
			tgl_sync_ff <= {tgl_sync_ff[SS-2:0], rx_tgl_ff};
			wp_sync_ff <= {wp_sync_ff[SS-2:0], wp_n};
			strobe_sync_ff <= {strobe_sync_ff[SS-2:0], restore_strobe_pin_n};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			strobe_prev_ff <= 1'b1;
		end else begin
			strobe_prev_ff <= strobe_sync_ff[SS-1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame acceptance and restore events

	logic seen_tgl_ff;
	logic boot_ff;
	logic strobe_fall;
	logic restore_evt;
	logic frame_ready;
	logic exec;
	logic store_ok;
	qpd_pkg::qpd_cmd_t cmd;
	logic [3:0] addr;
	logic [NW-1:0] data;
	logic [1:0] widx;

	assign strobe_fall = strobe_prev_ff & ~strobe_sync_ff[SS-1];
	assign restore_evt = boot_ff | strobe_fall;
	assign frame_ready = (tgl_sync_ff[SS-1] != seen_tgl_ff) &
		cs_sync_ff[SS-1];
	// a restore event wins; the frame then waits one cycle
	assign exec = frame_ready & ~restore_evt;
	assign store_ok = wp_sync_ff[SS-1];

	assign cmd = qpd_pkg::qpd_cmd_t'(rx_word_ff[qpd_pkg::CMD_MSB:qpd_pkg::CMD_LSB]);
	assign addr = rx_word_ff[qpd_pkg::ADDR_MSB:qpd_pkg::ADDR_LSB];
	assign data = rx_word_ff[qpd_pkg::DATA_MSB:qpd_pkg::DATA_LSB];
	assign widx = addr[1:0];

	always_ff @(posedge clk) begin
		if (rst) begin
			seen_tgl_ff <= 1'b0;
		end else if (exec) begin
			seen_tgl_ff <= tgl_sync_ff[SS-1];
		end
	end

	// power-on reload fires on the first cycle after rst
	always_ff @(posedge clk) begin
		boot_ff <= rst;
	end

	////////////////////////////////////////////////////////////////////////
	// nonvolatile store: four wiper slots and twelve user bytes

	logic [NW-1:0] store_ff [NV_DEPTH];

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int k = 0; k < NV_DEPTH; k++) begin
				store_ff[k] <= (k <= int'(qpd_pkg::NV_WIPER_LAST)) ?
					qpd_pkg::NV_RESET_WIPER : qpd_pkg::NV_RESET_USER;
			end
		end else if (exec && store_ok) begin
			if (cmd == qpd_pkg::CMD_STORE_WIPER && is_wiper_addr(addr)) begin
				store_ff[addr] <= NW'(wiper_code[widx]);
			end else if (cmd == qpd_pkg::CMD_STORE_BYTE) begin
				store_ff[addr] <= data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// wiper registers

	logic [WIPERS-1:0][CODE_W-1:0] wiper_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			wiper_ff <= '0;
		end else if (restore_evt) begin
			for (int k = 0; k < WIPERS; k++) begin
				wiper_ff[k] <= store_ff[k][CODE_W-1:0];
			end
		end else if (exec) begin
			unique case (cmd)
				qpd_pkg::CMD_WRITE_WIPER: begin
					if (is_wiper_addr(addr)) begin
						wiper_ff[widx] <= data[CODE_W-1:0];
					end
				end
				qpd_pkg::CMD_RESTORE_ONE: begin
					if (is_wiper_addr(addr)) begin
						wiper_ff[widx] <= store_ff[addr][CODE_W-1:0];
					end
				end
				qpd_pkg::CMD_RESTORE_ALL: begin
					for (int k = 0; k < WIPERS; k++) begin
						wiper_ff[k] <= store_ff[k][CODE_W-1:0];
					end
				end
				qpd_pkg::CMD_INC_ONE: begin
					if (is_wiper_addr(addr)) begin
						wiper_ff[widx] <= inc_code(wiper_ff[widx]);
					end
				end
				qpd_pkg::CMD_INC_ALL: begin
					for (int k = 0; k < WIPERS; k++) begin
						wiper_ff[k] <= inc_code(wiper_ff[k]);
					end
				end
				qpd_pkg::CMD_DEC_ONE: begin
					if (is_wiper_addr(addr)) begin
						wiper_ff[widx] <= dec_code(wiper_ff[widx]);
					end
				end
				qpd_pkg::CMD_DEC_ALL: begin
					for (int k = 0; k < WIPERS; k++) begin
						wiper_ff[k] <= dec_code(wiper_ff[k]);
					end
				end
				qpd_pkg::CMD_SHL_ONE: begin
					if (is_wiper_addr(addr)) begin
						wiper_ff[widx] <= shl_code(wiper_ff[widx]);
					end
				end
				qpd_pkg::CMD_SHL_ALL: begin
					for (int k = 0; k < WIPERS; k++) begin
						wiper_ff[k] <= shl_code(wiper_ff[k]);
					end
				end
				qpd_pkg::CMD_SHR_ONE: begin
					if (is_wiper_addr(addr)) begin
						wiper_ff[widx] <= wiper_ff[widx] >> 1;
					end
				end
				qpd_pkg::CMD_SHR_ALL: begin
					for (int k = 0; k < WIPERS; k++) begin
						wiper_ff[k] <= wiper_ff[k] >> 1;
					end
				end
				// idle, stores and reads leave the wipers alone
				qpd_pkg::CMD_IDLE, qpd_pkg::CMD_STORE_WIPER,
				qpd_pkg::CMD_STORE_BYTE, qpd_pkg::CMD_READ_STORE,
				qpd_pkg::CMD_READ_WIPER: begin
					wiper_ff <= wiper_ff;
				end
			endcase
		end
	end

	assign wiper_code = wiper_ff;

	////////////////////////////////////////////////////////////////////////
	// word returned in the next frame

	always_ff @(posedge clk) begin
		if (rst) begin
			out_word_ff <= '0;
		end else if (exec) begin
			if (cmd == qpd_pkg::CMD_READ_STORE) begin
				out_word_ff <= {rx_word_ff[W-1:NW], store_ff[addr]};
			end else if (cmd == qpd_pkg::CMD_READ_WIPER) begin
				out_word_ff <= {rx_word_ff[W-1:NW],
					NW'(wiper_ff[widx])};
			end else begin
				out_word_ff <= rx_word_ff;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// power state: restores leave the read state on until an idle word

	always_ff @(posedge clk) begin
		if (rst) begin
			read_power_state <= 1'b0;
		end else if (exec) begin
			if (cmd == qpd_pkg::CMD_RESTORE_ONE ||
				cmd == qpd_pkg::CMD_RESTORE_ALL) begin
				read_power_state <= 1'b1;
			end else if (cmd == qpd_pkg::CMD_IDLE) begin
				read_power_state <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// tap decoding

	qpd_tap_if #(.WIPERS(WIPERS), .CODE_W(CODE_W), .TAPS(TAPS)) tap_bus ();

	assign tap_bus.code = wiper_ff;
	assign tap_sel = tap_bus.tap;

	qpd_tap_decoder #(
		.WIPERS(WIPERS),
		.CODE_W(CODE_W),
		.TAPS(TAPS)
	) u_tap_decoder (
		.clk(clk),
		.rst(rst),
		.taps(tap_bus.dec)
	);

endmodule

// >>> qpd_properties.sv
// port-level checker for the quad potentiometer command decoder
`timescale 1ns/10ps
module qpd_properties #(
	parameter int WIPERS = 4,
	parameter int CODE_W = 6,
	parameter int TAPS = 64
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe,
	// side pins
	input wire logic wp_n,
	input wire logic restore_strobe_pin_n,
	// wiper state
	input wire logic [WIPERS-1:0][CODE_W-1:0] wiper_code,
	input wire logic [WIPERS-1:0][TAPS-1:0] tap_sel,
	input wire logic read_power_state
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	for (genvar g = 0; g < WIPERS; g++) begin : gen_w
		a_tap_onehot: assert property ($onehot(tap_sel[g]))
			else $error("tap select not one-hot");
		a_tap_decode: assert property (
			tap_sel[g] == (TAPS'(1) << $past(wiper_code[g])))
			else $error("tap does not follow wiper code");
	end
	a_oe_frame: assert property (sdo_oe == !cs_n)
		else $error("output enable outside frame");
	a_frame_hold: assert property (
		(!cs_n && restore_strobe_pin_n)[*6] |=> $stable(wiper_code))
		else $error("wiper moved inside a frame");
	a_rise_hold: assert property (
		restore_strobe_pin_n[*6] ##0 $rose(cs_n) |=> $stable(wiper_code))
		else $error("wiper moved before chip select was synced");
	a_power_quiet: assert property ($changed(read_power_state) |-> cs_n)
		else $error("power state changed inside a frame");
	a_reset_values: assert property (disable iff (1'b0)
		rst ##1 rst |-> wiper_code == '0 && !read_power_state)
		else $error("reset values wrong");
	a_boot_reload: assert property (
		$fell(rst) |-> ##[1:3] wiper_code == {WIPERS{6'h20}})
		else $error("no reload after reset");
	c_wiper_move: cover property ($changed(wiper_code[0]));
	c_power: cover property ($rose(read_power_state));
	c_strobe: cover property ($fell(restore_strobe_pin_n));
endmodule

bind qpd_command_decoder qpd_properties #(.WIPERS(WIPERS),
	.CODE_W(CODE_W), .TAPS(TAPS)) u_props (.clk(clk), .rst(rst),
	.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
	.wp_n(wp_n), .restore_strobe_pin_n(restore_strobe_pin_n),
	.wiper_code(wiper_code), .tap_sel(tap_sel),
	.read_power_state(read_power_state));

// >>> qpd_host_model.sv
// serial host model: 16-bit frames, msb first, 48 ns link clock
`timescale 1ns/10ps
module qpd_host_model (
	// link pins
	output logic sclk,
	output logic cs_n,
	output logic sdi,
	input wire logic sdo
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
	end
	// sclk stands low outside frames; sdi flips once released
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		cs_n = 1'b0;
		for (int k = 15; k >= 0; k--) begin
			sdi = w[k];
			// take sdo while it stands, before the edge that moves the mux
			#24 r[k] = sdo;
			sclk = 1'b1;
			#24 sclk = 1'b0;
		end
		#24 cs_n = 1'b1;
		sdi = ~sdi;
		#150;
	endtask
endmodule

// >>> tb_top.sv
// self-checking bench for the quad potentiometer command decoder
`timescale 1ns/10ps
module tb_top;
	logic clk;
	logic rst;
	logic sclk;
	logic cs_n;
	logic sdi;
	logic sdo;
	logic sdo_oe;
	logic wp_n;
	logic strobe_n;
	logic [3:0][5:0] code;
	logic [3:0][63:0] taps;
	logic rps;
	logic [15:0] r;
	int miscompares = 0;
	int tests_run = 0;

	qpd_command_decoder uut (.clk(clk), .rst(rst), .sclk(sclk),
		.cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .wp_n(wp_n),
		.restore_strobe_pin_n(strobe_n), .wiper_code(code),
		.tap_sel(taps), .read_power_state(rps));
	qpd_host_model host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_c(input logic [5:0] got, input logic [5:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t code %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_t(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t taps %h expected %h", $time, got, exp);
		end
	endtask
	task automatic send(input logic [15:0] w);
		host.xfer(w, r);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_boot();
		for (int i = 0; i < 4; i++) begin
			chk_c(code[i], 6'h20);
			chk_t(taps[i], 64'h1 << 32);
		end
		chk_c({5'h0, sdo_oe}, 6'h00);
		chk_c({5'h0, rps}, 6'h00);
		$display("test boot done");
	endtask
	task automatic t_inc_store();
		send(16'hb010);
		chk_c(code[0], 6'h10);
		send(16'he000);
		chk_w(r, 16'hb010);
		chk_c(code[0], 6'h11);
		send(16'he0ff);
		chk_w(r, 16'he000);
		chk_c(code[0], 6'h12);
		send(16'h2000);
		send(16'hb005);
		send(16'h1000);
		chk_c(code[0], 6'h12);
		chk_c({5'h0, rps}, 6'h01);
		send(16'h0000);
		chk_w(r, 16'h1000);
		chk_c({5'h0, rps}, 6'h00);
		chk_c(code[0], 6'h12);
		$display("test inc_store done");
	endtask
	task automatic t_wp();
		@(posedge clk);
		#1 wp_n = 1'b0;
		send(16'hb007);
		send(16'h2000);
		send(16'h3f77);
		@(posedge clk);
		#1 wp_n = 1'b1;
		send(16'h1000);
		chk_c(code[0], 6'h12);
		send(16'h9f00);
		send(16'h0000);
		chk_w(r, 16'h9f00);
		$display("test write_protect done");
	endtask
	task automatic t_shift();
		logic [5:0] a[5] = '{6'h00, 6'h10, 6'h21, 6'h3f, 6'h20};
		logic [5:0] e[5] = '{6'h01, 6'h20, 6'h3f, 6'h3f, 6'h3f};
		for (int i = 0; i < 5; i++) begin
			send({8'hb0, 2'b00, a[i]});
			send(16'hc0ff);
			chk_c(code[0], e[i]);
		end
		send(16'ha000);
		send(16'h0000);
		chk_w(r, 16'ha03f);
		send(16'hb22a);
		chk_c(code[2], 6'h2a);
		chk_c(code[0], 6'h3f);
		$display("test shift done");
	endtask
	task automatic t_user();
		for (int a = 5; a < 16; a++) begin
			send({4'h3, a[3:0], a[3:0], ~a[3:0]});
		end
		send(16'h35aa);
		send(16'h9500);
		chk_w(r, 16'h35aa);
		send(16'h0000);
		chk_w(r, 16'h95aa);
		for (int a = 6; a < 16; a++) begin
			send({4'h9, a[3:0], 8'h00});
			send(16'h0000);
			chk_w(r, {4'h9, a[3:0], a[3:0], ~a[3:0]});
		end
		send(16'h31c5);
		send(16'h8000);
		chk_c(code[1], 6'h05);
		chk_c(code[0], 6'h12);
		send(16'h0000);
		$display("test user_bytes done");
	endtask
	task automatic t_strobe();
		send(16'hb03f);
		send(16'hb13f);
		@(posedge clk);
		#1 strobe_n = 1'b0;
		repeat (4) @(posedge clk);
		#1 strobe_n = 1'b1;
		repeat (10) @(posedge clk);
		chk_c(code[0], 6'h12);
		chk_c(code[1], 6'h05);
		$display("test strobe done");
	endtask
	task automatic t_ops();
		send(16'h4000);
		chk_c(code[0], 6'h09);
		send(16'h6000);
		chk_c(code[0], 6'h08);
		send(16'hf000);
		chk_c(code[1], 6'h06);
		chk_c(code[2], 6'h21);
		send(16'h7000);
		chk_c(code[3], 6'h20);
		send(16'hd000);
		chk_c(code[1], 6'h0a);
		chk_c(code[2], 6'h3f);
		send(16'h5000);
		chk_c(code[3], 6'h1f);
		chk_c(code[0], 6'h08);
		send(16'hb03f);
		send(16'he000);
		chk_c(code[0], 6'h3f);
		chk_t(taps[0], 64'h1 << 63);
		send(16'hb000);
		chk_t(taps[0], 64'h1);
		send(16'h6000);
		chk_c(code[0], 6'h00);
		send(16'hb43f);
		chk_c(code[0], 6'h00);
		$display("test ops done");
	endtask
	task automatic t_reset();
		@(posedge clk);
		#1 rst = 1'b1;
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		repeat (10) @(posedge clk);
		t_boot();
		$display("test mid_reset done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#300000;
		miscompares++;
		summarize();
	end
	initial begin
		rst = 1'b1;
		wp_n = 1'b1;
		strobe_n = 1'b1;
		repeat (16) @(posedge clk);
		#1 rst = 1'b0;
		repeat (10) @(posedge clk);
		t_boot();
		t_inc_store();
		t_wp();
		t_shift();
		t_user();
		t_strobe();
		t_ops();
		t_reset();
		summarize();
	end
endmodule
